//--- hw/ptbp_pkg.sv
// Shared constants and state type for the PCI target backend pacing block
package ptbp_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BE_W      = 4;
  localparam int unsigned ADDR_W    = 22;
  localparam int unsigned LAT_W     = 3;
  localparam int unsigned WAIT_W    = 5;
  // Cycles without data before the target gives up with a disconnect
  localparam logic [WAIT_W-1:0] STALL_TIMEOUT = 5'h10;
  localparam logic [WAIT_W-1:0] WAIT_ZERO     = 5'h00;
  localparam logic [WAIT_W-1:0] WAIT_ONE      = 5'h01;
  localparam logic [LAT_W-1:0]  LAT_ZERO      = 3'h0;
  localparam logic [LAT_W-1:0]  LAT_ONE       = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO     = 22'h000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE      = 22'h000001;
  localparam logic [DATA_W-1:0] DATA_ZERO     = 32'h00000000;
  localparam logic [BE_W-1:0]   STROBE_NONE   = 4'h0;
  localparam logic              PIN_INACTIVE  = 1'b1;
  localparam logic              PIN_ACTIVE    = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_ABORT,
    ST_RETRY,
    ST_DISC
  } ptbp_state_t;
endpackage

//--- hw/ptbp_irq_fwd.sv
// Backend interrupt sampler driving the open-drain PCI interrupt line
`timescale 1ns/1ps
`default_nettype none
module ptbp_irq_fwd (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Backend interrupt, active low, from outside the clock domain
  input  wire logic backend_interrupt_in_n,
  // Open-drain interrupt pin
  output logic      inta_out,
  output logic      inta_oe
);
  logic sync_first;
  logic sync_second;
  logic next_sync_first;
  logic next_sync_second;

  always_comb begin
    next_sync_first  = ~backend_interrupt_in_n;
    next_sync_second = sync_first;
  end

  // Two stages give the fixed two-cycle delay to the pin
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first  <= next_sync_first;
      sync_second <= next_sync_second;
    end
  end

  // Open drain: only ever pulls low
  assign inta_out = ptbp_pkg::PIN_ACTIVE;
  assign inta_oe  = sync_second;

  property p_inta_delay;
    @(posedge clock) disable iff (!rst_n)
      ($past(rst_n, 1) && $past(rst_n, 2)) |-> (inta_oe == !$past(backend_interrupt_in_n, 2));
  endproperty
  a_inta_delay: assert property (p_inta_delay)
    else $error("INTA does not follow backend interrupt by two cycles");
endmodule
`default_nettype wire

//--- hw/ptbp_target.sv
// PCI target flow control between the PCI bus and a paced backend
// Notes on behaviour
// - Write ready gives TRDY next, strobes after
// - Strobes also depend on initiator IRDY
// - Read ready pulses strobe; TRDY next cycle
// - IRDY wait drops strobes one cycle later
// - Ready drop deasserts TRDY one cycle later
// - Read ready drop: strobe off, then TRDY
// - Latency zero: data valid with strobe
// - Latency N: data required N cycles later
// - Backend error: STOP on, DEVSEL off together
// - Grant or busy at start: retry
// - Stall time-out: disconnect without data
// - Grant request once controller idle
// - Grant held with request, drops cycle after
// - Interrupt reaches INTA two cycles later
// - Direction and space flags held between starts
// - Address advances after each active strobe unless a start loads it
`timescale 1ns/1ps
`default_nettype none
module ptbp_target (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  // PCI bus, same clock
  input  wire logic                           frame_n,
  input  wire logic                           irdy_n,
  input  wire logic [ptbp_pkg::DATA_W-1:0]    ad_in,
  input  wire logic [ptbp_pkg::BE_W-1:0]      cbe_n,
  output logic                                trdy_n,
  output logic                                stop_n,
  output logic                                devsel_n,
  output logic                                target_oe,
  output logic [ptbp_pkg::DATA_W-1:0]         ad_out,
  output logic                                ad_oe,
  output logic                                inta_out,
  output logic                                inta_oe,
  // Address decoder
  input  wire logic                           target_hit,
  input  wire logic                           hit_is_read,
  input  wire logic                           hit_space,
  input  wire logic [ptbp_pkg::ADDR_W-1:0]    hit_address,
  input  wire logic [ptbp_pkg::LAT_W-1:0]     latency_select,
  // Backend transfer side
  input  wire logic                           backend_write_ready,
  input  wire logic                           backend_read_ready,
  input  wire logic [ptbp_pkg::DATA_W-1:0]    backend_read_data,
  input  wire logic                           backend_error,
  input  wire logic                           backend_busy,
  output logic                                transaction_start_pulse,
  output logic                                read_direction_flag,
  output logic                                write_direction_flag,
  output logic                                space_select_flag,
  output logic [ptbp_pkg::LAT_W-1:0]          addr_data_latency_setting,
  output logic                                data_required,
  output logic [ptbp_pkg::ADDR_W-1:0]         mem_address,
  output logic [ptbp_pkg::DATA_W-1:0]         mem_write_data,
  output logic [ptbp_pkg::BE_W-1:0]           write_byte_strobes,
  output logic                                read_data_strobe,
  // Backend arbitration and interrupt
  input  wire logic                           backend_bus_request,
  output logic                                backend_bus_grant,
  input  wire logic                           backend_interrupt_in_n
);
  ptbp_pkg::ptbp_state_t         state, next_state;
  logic                          next_trdy_n, next_stop_n, next_devsel_n, next_start, next_grant;
  logic                          next_read_flag, next_space_flag, lat_run, next_lat_run, next_read_data_strobe;
  logic                          claimed, data_done, last_done, strobe_any, lat_ok, timed_out;
  logic [ptbp_pkg::DATA_W-1:0]   next_ad_out, next_mem_write_data;
  logic [ptbp_pkg::LAT_W-1:0]    next_latency, lat_cnt, next_lat_cnt;
  logic [ptbp_pkg::ADDR_W-1:0]   next_mem_address;
  logic [ptbp_pkg::BE_W-1:0]     next_write_byte_strobes;
  logic [ptbp_pkg::WAIT_W-1:0]   wait_cnt, next_wait_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  assign claimed    = (state == ptbp_pkg::ST_XFER);
  assign data_done  = claimed && !trdy_n && !irdy_n;
  assign last_done  = data_done && frame_n;
  assign strobe_any = read_data_strobe || (write_byte_strobes != ptbp_pkg::STROBE_NONE);
  assign lat_ok     = (lat_cnt == ptbp_pkg::LAT_ZERO);
  assign timed_out  = (wait_cnt == ptbp_pkg::STALL_TIMEOUT - ptbp_pkg::WAIT_ONE);

  // PCI termination state and target pins
  always_comb begin
    next_state    = state;
    next_trdy_n   = ptbp_pkg::PIN_INACTIVE;
    next_stop_n   = ptbp_pkg::PIN_INACTIVE;
    next_devsel_n = ptbp_pkg::PIN_INACTIVE;
    next_start    = 1'b0;
    next_wait_cnt = ptbp_pkg::WAIT_ZERO;
    case (state)
      ptbp_pkg::ST_IDLE: begin
        if (target_hit) begin
          next_start    = 1'b1;
          next_devsel_n = ptbp_pkg::PIN_ACTIVE;
          if (backend_bus_grant || backend_busy) begin
            next_state  = ptbp_pkg::ST_RETRY;
            next_stop_n = ptbp_pkg::PIN_ACTIVE;
          end else begin
            next_state  = ptbp_pkg::ST_XFER;
          end
        end
      end
      ptbp_pkg::ST_XFER: begin
        next_devsel_n = ptbp_pkg::PIN_ACTIVE;
        next_wait_cnt = (trdy_n && !timed_out) ? wait_cnt + ptbp_pkg::WAIT_ONE : ptbp_pkg::WAIT_ZERO;
        if (backend_error) begin
          next_state    = ptbp_pkg::ST_ABORT;
          next_stop_n   = ptbp_pkg::PIN_ACTIVE;
          next_devsel_n = ptbp_pkg::PIN_INACTIVE;
        end else if (backend_busy || timed_out) begin
          next_state  = ptbp_pkg::ST_DISC;
          next_stop_n = ptbp_pkg::PIN_ACTIVE;
        end else if (last_done) begin
          next_state    = ptbp_pkg::ST_IDLE;
          next_devsel_n = ptbp_pkg::PIN_INACTIVE;
        end else if (read_direction_flag) begin
          // TRDY trails the strobe that caught the data
          next_trdy_n = !(read_data_strobe && lat_ok);
        end else begin
          // Ready now, TRDY next; a dropped ready drops TRDY next
          next_trdy_n = !backend_write_ready;
        end
      end
      ptbp_pkg::ST_ABORT, ptbp_pkg::ST_RETRY, ptbp_pkg::ST_DISC: begin
        // Initiator drops FRAME first, so FRAME high ends the stop phase
        if (frame_n) begin
          next_state = ptbp_pkg::ST_IDLE;
        end else begin
          next_stop_n   = ptbp_pkg::PIN_ACTIVE;
          next_devsel_n = (state == ptbp_pkg::ST_ABORT) ? ptbp_pkg::PIN_INACTIVE : ptbp_pkg::PIN_ACTIVE;
        end
      end
      default: begin
        next_state = ptbp_pkg::ST_IDLE;
      end
    endcase
  end

  // Backend handshake, address and data path
  always_comb begin
    next_read_flag          = read_direction_flag;
    next_space_flag         = space_select_flag;
    next_latency            = addr_data_latency_setting;
    next_lat_cnt            = lat_cnt;
    next_lat_run            = lat_run;
    next_mem_address        = mem_address;
    next_mem_write_data     = mem_write_data;
    next_ad_out             = ad_out;
    next_write_byte_strobes = ptbp_pkg::STROBE_NONE;
    next_read_data_strobe   = 1'b0;
    if (next_start) begin
      // Flags change only at a start pulse
      next_read_flag   = hit_is_read;
      next_space_flag  = hit_space;
      next_latency     = latency_select;
      next_lat_cnt     = latency_select;
      next_lat_run     = 1'b0;
      next_mem_address = hit_address;
    end else begin
      if (strobe_any) begin
        next_mem_address = mem_address + ptbp_pkg::ADDR_ONE;
      end
      // Latency count starts with the first strobe
      if (!lat_ok && (lat_run || strobe_any)) begin
        next_lat_cnt = lat_cnt - ptbp_pkg::LAT_ONE;
        next_lat_run = 1'b1;
      end
    end
    // Strobes qualified by IRDY of this cycle, so a wait shows one cycle later
    if (claimed && !read_direction_flag && data_done) begin
      next_write_byte_strobes = ~cbe_n;
      next_mem_write_data     = ad_in;
    end
    if (claimed && read_direction_flag && backend_read_ready && !irdy_n && !last_done && !backend_error) begin
      next_read_data_strobe = 1'b1;
    end
    if (read_data_strobe && lat_ok) begin
      next_ad_out = backend_read_data;
    end
  end
  // Backend bus grant only from an idle controller
  always_comb begin
    next_grant = backend_bus_request && (backend_bus_grant || (state == ptbp_pkg::ST_IDLE && !target_hit));
  end

  // Termination outputs and strobes go inactive under reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state                     <= ptbp_pkg::ST_IDLE;
      trdy_n                    <= ptbp_pkg::PIN_INACTIVE;
      stop_n                    <= ptbp_pkg::PIN_INACTIVE;
      devsel_n                  <= ptbp_pkg::PIN_INACTIVE;
      wait_cnt                  <= ptbp_pkg::WAIT_ZERO;
      transaction_start_pulse   <= 1'b0;
      read_direction_flag       <= 1'b0;
      space_select_flag         <= 1'b0;
      addr_data_latency_setting <= ptbp_pkg::LAT_ZERO;
      lat_cnt                   <= ptbp_pkg::LAT_ZERO;
      lat_run                   <= 1'b0;
      mem_address               <= ptbp_pkg::ADDR_ZERO;
      mem_write_data            <= ptbp_pkg::DATA_ZERO;
      ad_out                    <= ptbp_pkg::DATA_ZERO;
      write_byte_strobes        <= ptbp_pkg::STROBE_NONE;
      read_data_strobe          <= 1'b0;
      backend_bus_grant         <= 1'b0;
    end else begin
      state                     <= next_state;
      trdy_n                    <= next_trdy_n;
      stop_n                    <= next_stop_n;
      devsel_n                  <= next_devsel_n;
      wait_cnt                  <= next_wait_cnt;
      transaction_start_pulse   <= next_start;
      read_direction_flag       <= next_read_flag;
      space_select_flag         <= next_space_flag;
      addr_data_latency_setting <= next_latency;
      lat_cnt                   <= next_lat_cnt;
      lat_run                   <= next_lat_run;
      mem_address               <= next_mem_address;
      mem_write_data            <= next_mem_write_data;
      ad_out                    <= next_ad_out;
      write_byte_strobes        <= next_write_byte_strobes;
      read_data_strobe          <= next_read_data_strobe;
      backend_bus_grant         <= next_grant;
    end
  end

  assign write_direction_flag = !read_direction_flag;
  assign data_required        = lat_ok;
  assign target_oe            = (state != ptbp_pkg::ST_IDLE) || !devsel_n;
  assign ad_oe                = claimed && read_direction_flag;

  ptbp_irq_fwd u_irq (
    .clock                  (clock),
    .rst_n                  (rst_n),
    .backend_interrupt_in_n (backend_interrupt_in_n),
    .inta_out               (inta_out),
    .inta_oe                (inta_oe)
  );
  sequence s_rd_drop;
    claimed && read_direction_flag && !backend_read_ready && !last_done;
  endsequence
  sequence s_strobe_then_trdy_off;
    !read_data_strobe ##1 trdy_n;
  endsequence

  a_wr_trdy_follow: assert property (
      (claimed && !read_direction_flag && backend_write_ready && !backend_error && !backend_busy
       && !timed_out && !last_done) |=> !trdy_n)
    else $error("TRDY missing after write ready");
  a_wr_strobe_data: assert property (
      (data_done && !read_direction_flag) |=> (write_byte_strobes == ~$past(cbe_n)) && (mem_write_data == $past(ad_in)))
    else $error("Write strobes not matching completed phase");
  a_irdy_wait_off: assert property (
      (claimed && irdy_n) |=> (write_byte_strobes == ptbp_pkg::STROBE_NONE) && !read_data_strobe)
    else $error("Strobe active after initiator wait");
  a_rd_strobe_trdy: assert property (
      (claimed && read_data_strobe && lat_ok && !backend_error && !backend_busy && !timed_out && !last_done)
      |=> !trdy_n && (ad_out == $past(backend_read_data)))
    else $error("Read strobe not followed by TRDY with latched data");
  a_rd_drop_order: assert property (
      s_rd_drop |=> s_strobe_then_trdy_off)
    else $error("Read ready drop not ending strobe then TRDY");
  a_abort_pins: assert property (
      (claimed && backend_error) |=> !stop_n && devsel_n && trdy_n)
    else $error("Target abort pins wrong");
  a_retry_pins: assert property (
      (state == ptbp_pkg::ST_IDLE && target_hit && (backend_bus_grant || backend_busy))
      |=> (!stop_n && !devsel_n && trdy_n) ##1 trdy_n)
    else $error("Retry pins wrong");
  a_disc_stop: assert property (
      (claimed && !backend_error && (backend_busy || timed_out)) |=> !stop_n && !devsel_n && trdy_n)
    else $error("Disconnect without data missing");
  a_grant_idle: assert property (
      (state == ptbp_pkg::ST_IDLE && !target_hit && backend_bus_request) |=> backend_bus_grant)
    else $error("Grant not given while idle");
  a_grant_drop: assert property (
      (backend_bus_grant && !backend_bus_request) |=> !backend_bus_grant)
    else $error("Grant held after request dropped");
  a_flags_hold: assert property (
      !next_start |=> $stable(read_direction_flag) && $stable(space_select_flag))
    else $error("Direction or space flag changed without start");
  a_addr_step: assert property (
      (strobe_any && !next_start) |=> (mem_address == $past(mem_address) + ptbp_pkg::ADDR_ONE))
    else $error("Address did not advance after strobe");
  a_reset_clear: assert property (
    disable iff (1'b0)
      !rst_n |=> !backend_bus_grant && stop_n && trdy_n && !read_data_strobe && !inta_oe)
    else $error("Outputs not cleared by reset");
endmodule
`default_nettype wire

//--- testbench/ptbp_backend_model.sv
// Behavioural backend memory that paces the target through its ready lines
`timescale 1ns/1ps
`default_nettype none
module ptbp_backend_model (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Pacing control from the bench
  input  wire logic                        allow_write,
  input  wire logic                        allow_read,
  // Target side of the backend bus
  input  wire logic [ptbp_pkg::ADDR_W-1:0] mem_address,
  input  wire logic                        read_data_strobe,
  input  wire logic [ptbp_pkg::BE_W-1:0]   write_byte_strobes,
  input  wire logic [ptbp_pkg::DATA_W-1:0] mem_write_data,
  output logic                             backend_write_ready,
  output logic                             backend_read_ready,
  output logic [ptbp_pkg::DATA_W-1:0]      backend_read_data,
  output logic [ptbp_pkg::DATA_W-1:0]      last_write
);
  logic [ptbp_pkg::DATA_W-1:0] held;

  // Readies move just after an edge, half a cycle behind the bench
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      backend_write_ready <= 1'b0;
      backend_read_ready  <= 1'b0;
      held                <= 32'h00000000;
      last_write          <= 32'h00000000;
    end else begin
      backend_write_ready <= allow_write;
      backend_read_ready  <= allow_read;
      held                <= backend_read_data;
      if (write_byte_strobes != 4'h0) begin
        last_write <= mem_write_data;
      end
    end
  end

  // Off the strobe the bus keeps toggling, so stale data never looks valid
  assign backend_read_data = read_data_strobe ? {10'h155, mem_address} : ~held;
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the PCI target pacing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module testbench;
  typedef struct {logic [3:0] cbe; logic [3:0] strobe; logic [31:0] data; logic space;} ptbp_row_t;
  ptbp_row_t   rows[3] = '{'{4'h0, 4'hf, 32'hcafe0001, 1'b0}, '{4'ha, 4'h5, 32'h12345678, 1'b1},
                           '{4'he, 4'h1, 32'h0badf00d, 1'b0}};
  logic        clock = 1'b0, rst_n = 1'b0, frame_n = 1'b1, irdy_n = 1'b1, target_hit = 1'b0;
  logic        hit_is_read = 1'b0, hit_space = 1'b0, backend_error = 1'b0, backend_busy = 1'b0;
  logic        backend_bus_request = 1'b0, backend_interrupt_in_n = 1'b1, allow_write = 1'b0;
  logic        allow_read = 1'b0;
  logic [31:0] ad_in = 32'h00000000;
  logic [3:0]  cbe_n = 4'hf;
  logic [21:0] hit_address = 22'h000000;
  logic [2:0]  latency_select = 3'h0;
  logic        trdy_n, stop_n, devsel_n, target_oe, ad_oe, inta_out, inta_oe, transaction_start_pulse;
  logic        read_direction_flag, write_direction_flag, space_select_flag, data_required;
  logic        read_data_strobe, backend_bus_grant, backend_write_ready, backend_read_ready;
  logic [31:0] ad_out, mem_write_data, backend_read_data, last_write;
  logic [2:0]  addr_data_latency_setting;
  logic [21:0] mem_address;
  logic [3:0]  write_byte_strobes;
  int          n_errors = 0, checks_done = 0, i;

  ptbp_target dut_u (.clock, .rst_n, .frame_n, .irdy_n, .ad_in, .cbe_n, .trdy_n, .stop_n, .devsel_n,
    .target_oe, .ad_out, .ad_oe, .inta_out, .inta_oe, .target_hit, .hit_is_read, .hit_space,
    .hit_address, .latency_select, .backend_write_ready, .backend_read_ready, .backend_read_data,
    .backend_error, .backend_busy, .transaction_start_pulse, .read_direction_flag,
    .write_direction_flag, .space_select_flag, .addr_data_latency_setting, .data_required,
    .mem_address, .mem_write_data, .write_byte_strobes, .read_data_strobe, .backend_bus_request,
    .backend_bus_grant, .backend_interrupt_in_n);

  ptbp_backend_model model_u (.clock, .rst_n, .allow_write, .allow_read, .mem_address,
    .read_data_strobe, .write_byte_strobes, .mem_write_data, .backend_write_ready,
    .backend_read_ready, .backend_read_data, .last_write);

  always #4 clock = ~clock;

  task automatic step(int n = 1);
    repeat (n) @(negedge clock);
  endtask

  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Decoder hit in one cycle, returns in the start cycle
  task automatic start(logic rd, logic [21:0] a, logic [2:0] lat);
    hit_is_read = rd;
    hit_address = a;
    latency_select = lat;
    target_hit = 1'b1;
    frame_n = 1'b0;
    step();
    target_hit = 1'b0;
  endtask

  // Initiator ends the cycle: FRAME first, IRDY a cycle later
  task automatic wait_idle;
    frame_n = 1'b1;
    step();
    irdy_n = 1'b1;
    for (i = 0; i < 30 && devsel_n !== 1'b1; i++) step();
    if (i == 30) begin
      n_errors++;
      stop_test();
    end
    step();
  endtask

  initial begin
    step(2);
    `CHK({trdy_n, stop_n, devsel_n, backend_bus_grant, inta_oe, read_data_strobe, write_byte_strobes}, 10'h380)
    `CHK(target_oe, 1'b0)
    rst_n = 1'b1;
    step(2);
    foreach (rows[k]) begin
      hit_space = rows[k].space;
      start(1'b0, 22'h000100 + 22'(k), 3'h0);
      `CHK({transaction_start_pulse, write_direction_flag, devsel_n, target_oe}, 4'b1101)
      allow_write = 1'b1;
      irdy_n = 1'b0;
      frame_n = 1'b1;
      ad_in = rows[k].data;
      cbe_n = rows[k].cbe;
      step(2);
      `CHK(trdy_n, 1'b0)
      allow_write = 1'b0;
      step();
      `CHK({write_byte_strobes, mem_write_data}, {rows[k].strobe, rows[k].data})
      irdy_n = 1'b1;
      step();
      `CHK({mem_address, space_select_flag, addr_data_latency_setting}, {22'h000101 + 22'(k), rows[k].space, 3'h0})
      `CHK(last_write, rows[k].data)
    end
    // Read burst, backend pause, IRDY wait, then stall time-out
    start(1'b1, 22'h000200, 3'h0);
    `CHK({read_direction_flag, ad_oe}, 2'b11)
    allow_read = 1'b1;
    irdy_n = 1'b0;
    step(2);
    `CHK({read_data_strobe, data_required, trdy_n}, 3'b111)
    allow_read = 1'b0;
    step();
    `CHK({trdy_n, ad_out, mem_address}, {1'b0, 10'h155, 22'h000200, 22'h000201})
    step();
    `CHK(read_data_strobe, 1'b0)
    step();
    `CHK(trdy_n, 1'b1)
    allow_read = 1'b1;
    irdy_n = 1'b1;
    step(2);
    `CHK(read_data_strobe, 1'b0)
    allow_read = 1'b0;
    for (i = 0; i < 24 && stop_n !== 1'b0; i++) step();
    if (i == 24) begin
      n_errors++;
      stop_test();
    end
    `CHK({stop_n, devsel_n, trdy_n}, 3'b001)
    wait_idle();
    // Write with IRDY wait, then backend error
    start(1'b0, 22'h000300, 3'h0);
    allow_write = 1'b1;
    irdy_n = 1'b0;
    step(3);
    `CHK(write_byte_strobes, ~cbe_n)
    irdy_n = 1'b1;
    allow_write = 1'b0;
    step();
    backend_error = 1'b1;
    step();
    `CHK({write_byte_strobes, stop_n, devsel_n, trdy_n}, 7'b0000011)
    backend_error = 1'b0;
    wait_idle();
    // Read with latency one: first strobe only primes the address
    start(1'b1, 22'h000500, 3'h1);
    allow_read = 1'b1;
    irdy_n = 1'b0;
    step(2);
    `CHK({read_data_strobe, data_required, trdy_n}, 3'b101)
    step();
    `CHK({data_required, trdy_n, mem_address}, {2'b11, 22'h000501})
    step();
    `CHK({trdy_n, ad_out}, {1'b0, 10'h155, 22'h000501})
    allow_read = 1'b0;
    wait_idle();
    // Retry caused by grant, then by busy
    for (int m = 0; m < 2; m++) begin
      backend_bus_request = (m == 0);
      backend_busy = (m == 1);
      step();
      `CHK(backend_bus_grant, m == 0)
      start(1'b0, 22'h000400, 3'h3);
      `CHK({devsel_n, stop_n, trdy_n, addr_data_latency_setting}, 6'b001011)
      step(3);
      `CHK({trdy_n, backend_bus_grant}, {1'b1, m == 0})
      backend_bus_request = 1'b0;
      backend_busy = 1'b0;
      step();
      `CHK(backend_bus_grant, 1'b0)
      wait_idle();
    end
    // Reset in mid-run drops a standing grant
    backend_bus_request = 1'b1;
    step();
    rst_n = 1'b0;
    step();
    `CHK(backend_bus_grant, 1'b0)
    rst_n = 1'b1;
    backend_bus_request = 1'b0;
    step(2);
    backend_interrupt_in_n = 1'b0;
    step();
    `CHK(inta_oe, 1'b0)
    step();
    `CHK({inta_oe, inta_out}, 2'b10)
    backend_interrupt_in_n = 1'b1;
    step(3);
    `CHK(inta_oe, 1'b0)
    stop_test();
  end
endmodule
`default_nettype wire
